// ===== core/ftp_top.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ns
// Operation
// - Linked outputs share output 0 settings; in frequency mode output 1 lags by a quarter period.
// - Independent outputs each use their own settings block.
// - Independent outputs may run one in frequency and one in totalizer mode.
// - Frequency mode gives a continuous square wave never above 10 kHz.
// - Frequency maps linearly from base..span over parameter min..max.
// - Totalizer gives one pulse per quantity, width at least 1 ms, rate at most 500 Hz.
// - Totalizer source is only volume units or time units.
// - Totalizer pulses come only while the gate input reads open.
// - A shorted gate suppresses all totalizer pulses.
// - Each output has an off/on enable.
// - Each output has a frequency/totalizer mode select.
// - Each output has an open-drain/push-pull drive select.
// - On meter error frequency follows low, high, hold or user value.
// - Totalizer counts the set number of units before each pulse.
// - Totalizer pulse width and polarity are configurable.
module ftp_top
  import ftp_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS,
  parameter int S_MS   = MS_PER_S
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pv0,
  input  wire logic [15:0] pv1,
  input  wire logic [1:0]  vol_tick,
  input  wire logic        meter_err,
  input  wire logic        gate_in,
  output logic [1:0]       fto_pin,
  output logic [1:0]       fto_oe
);
  if (MS_CYC < 1 || S_MS < 1)
    $error("ftp_top: bad tick parameters");

  logic                    link_reg;
  logic [CFG_W-1:0]        cfg_reg   [2];
  logic [13:0]             fbase_reg [2];
  logic [13:0]             fspan_reg [2];
  logic [13:0]             fval_reg  [2];
  logic [15:0]             vmin_reg  [2];
  logic [15:0]             vmax_reg  [2];
  logic [15:0]             upp_reg   [2];
  logic [7:0]              pw_reg    [2];
  logic [15:0]             pv_w      [2];
  logic [13:0]             fnow_w    [2];
  logic [1:0]              wa_w;
  logic [1:0]              wb_w;
  logic [1:0]              tp_w;
  logic [1:0]              lvl_w;
  logic                    gate_m_reg;
  logic                    gate_reg;
  logic [$clog2(MS_CYC+1)-1:0] msc_reg;
  logic [$clog2(S_MS+1)-1:0]   sc_reg;
  logic                    sec_tick_reg;
  logic                    wr_w;
  logic                    blk_w;
  logic                    bi_w;
  logic [2:0]              fld_w;
  logic [31:0]             rd_w;
  logic                    err_w;

  assign pv_w[0] = pv0;
  assign pv_w[1] = pv1;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign wr_w  = psel && penable && pready && pwrite;
  assign blk_w = (paddr[7:5] == A_OUT0_BLK) || (paddr[7:5] == A_OUT1_BLK);
  assign bi_w  = paddr[7:5] == A_OUT1_BLK;
  assign fld_w = paddr[4:2];

  always_comb
  begin
    rd_w  = '0;
    err_w = 1'b0;
    if (paddr[1:0] != 2'h0)
      err_w = 1'b1;
    else if (paddr == A_CTRL)
      rd_w[CTRL_LINK] = link_reg;
    else if (paddr == A_STAT)
    begin
      rd_w[ST_GATE]              = gate_reg;
      rd_w[ST_MERR]              = meter_err;
      rd_w[ST_PIN_LSB +: 2]      = lvl_w;
    end
    else if (paddr == A_FREQ0)
      rd_w[13:0] = fnow_w[0];
    else if (paddr == A_FREQ1)
      rd_w[13:0] = link_reg ? fnow_w[0] : fnow_w[1];
    else if (blk_w)
    begin
      if (fld_w == F_CFG)
        rd_w[CFG_W-1:0] = cfg_reg[bi_w];
      else if (fld_w == F_FBASE)
        rd_w[13:0] = fbase_reg[bi_w];
      else if (fld_w == F_FSPAN)
        rd_w[13:0] = fspan_reg[bi_w];
      else if (fld_w == F_VMIN)
        rd_w[15:0] = vmin_reg[bi_w];
      else if (fld_w == F_VMAX)
        rd_w[15:0] = vmax_reg[bi_w];
      else if (fld_w == F_FVAL)
        rd_w[13:0] = fval_reg[bi_w];
      else if (fld_w == F_UPP)
        rd_w[15:0] = upp_reg[bi_w];
      else
        rd_w[7:0] = pw_reg[bi_w];
    end
    else
      err_w = 1'b1;
  end

  // Answer is set up during the setup cycle, so every access has no wait
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err_w;
      if (psel && !penable && !pwrite)
        prdata <= rd_w;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      link_reg <= 1'b0;
    else if (wr_w && !pslverr && paddr == A_CTRL)
      link_reg <= pwdata[CTRL_LINK];

  ////////////////////////////////////////////////////////////////////////////
  // Gate synchroniser and seconds tick for time units
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gate_m_reg <= 1'b0;
      gate_reg   <= 1'b0;
    end
    else
    begin
      gate_m_reg <= gate_in;
      gate_reg   <= gate_m_reg;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      msc_reg      <= '0;
      sc_reg       <= '0;
      sec_tick_reg <= 1'b0;
    end
    else
    begin
      sec_tick_reg <= 1'b0;
      if (msc_reg == ($clog2(MS_CYC+1))'(MS_CYC - 1))
      begin
        msc_reg <= '0;
        if (sc_reg == ($clog2(S_MS+1))'(S_MS - 1))
        begin
          sc_reg       <= '0;
          sec_tick_reg <= 1'b1;
        end
        else
          sc_reg <= sc_reg + 1'b1;
      end
      else
        msc_reg <= msc_reg + 1'b1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Per-output settings, generators and pin stage
  for (genvar n = 0; n < 2; n++)
  begin : g_out
    localparam int E = 0;
    logic              lk_w;
    logic [CFG_W-1:0]  c_w;
    logic              u_w;
    logic              lv_w;
    logic              wv_w;

    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        cfg_reg[n]   <= '0;
        fbase_reg[n] <= '0;
        fspan_reg[n] <= RST_FSPAN;
        fval_reg[n]  <= '0;
        vmin_reg[n]  <= '0;
        vmax_reg[n]  <= RST_VMAX;
        upp_reg[n]   <= RST_UPP;
        pw_reg[n]    <= RST_PW;
      end
      else if (wr_w && !pslverr && blk_w && bi_w == 1'(n))
      begin
        if (fld_w == F_CFG)
          cfg_reg[n] <= pwdata[CFG_W-1:0];
        else if (fld_w == F_FBASE)
          fbase_reg[n] <= pwdata[13:0];
        else if (fld_w == F_FSPAN)
          fspan_reg[n] <= pwdata[13:0];
        else if (fld_w == F_VMIN)
          vmin_reg[n] <= pwdata[15:0];
        else if (fld_w == F_VMAX)
          vmax_reg[n] <= pwdata[15:0];
        else if (fld_w == F_FVAL)
          fval_reg[n] <= pwdata[13:0];
        else if (fld_w == F_UPP)
          upp_reg[n] <= pwdata[15:0];
        else
          pw_reg[n] <= pwdata[7:0];
      end

    // Linked: output 1 takes output 0 settings and phase-shifted wave
    assign lk_w = link_reg && n == 1;
    assign c_w  = lk_w ? cfg_reg[E] : cfg_reg[n];
    assign u_w  = c_w[CFG_SRC] ? sec_tick_reg : vol_tick[lk_w ? E : n];
    assign wv_w = lk_w ? wb_w[E] : wa_w[n];

    ftp_freq_gen #(
      .FW        (14),
      .VW        (16)
    ) u_freq (
      .pclk      (pclk),
      .presetn   (presetn),
      .ena       (cfg_reg[n][CFG_EN] && !cfg_reg[n][CFG_MODE]),
      .fbase     (fbase_reg[n]),
      .fspan     (fspan_reg[n]),
      .fval      (fval_reg[n]),
      .vmin      (vmin_reg[n]),
      .vmax      (vmax_reg[n]),
      .pv        (pv_w[n]),
      .meter_err (meter_err),
      .err_sel   (cfg_reg[n][CFG_ERR_LSB +: 2]),
      .wave_a    (wa_w[n]),
      .wave_b    (wb_w[n]),
      .freq_now  (fnow_w[n])
    );

    ftp_tot_gen #(
      .MS_CYC    (MS_CYC),
      .OW        (4)
    ) u_tot (
      .pclk      (pclk),
      .presetn   (presetn),
      .ena       (c_w[CFG_EN] && c_w[CFG_MODE]),
      .unit_tick (u_w),
      .gate_open (gate_reg),
      .upp       (lk_w ? upp_reg[E] : upp_reg[n]),
      .pw_ms     (lk_w ? pw_reg[E] : pw_reg[n]),
      .pulse     (tp_w[n])
    );

    // Idle level: low in frequency mode, inverse of polarity in totalizer
    always_comb
    begin
      lv_w = 1'b0;
      if (c_w[CFG_MODE])
        lv_w = c_w[CFG_POL] ? tp_w[n] : !tp_w[n];
      else if (c_w[CFG_EN])
        lv_w = wv_w;
    end
    assign lvl_w[n] = lv_w;

    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
        fto_pin[n] <= 1'b0;
        fto_oe[n]  <= 1'b0;
      end
      else
      begin
        fto_pin[n] <= c_w[CFG_DRV] ? lv_w : 1'b0;
        fto_oe[n]  <= c_w[CFG_DRV] ? 1'b1 : !lv_w;
      end
  end
endmodule

// ===== core/ftp_pkg.sv
package ftp_pkg;
  // Clock and timing
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          MS_NS          = 1_000_000;
  localparam int          CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
  localparam int          MS_PER_S       = 1000;
  localparam int          F_MAX_HZ       = 10000;
  localparam int          TOT_MAX_HZ     = 500;
  localparam int          TOT_MIN_PW_MS  = 1;
  localparam int          TOT_MIN_PER_MS = MS_PER_S / TOT_MAX_HZ;
  localparam int          ACC_W          = 24;
  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, then output block numbers (address bits 7:5)
  localparam logic [7:0]  A_CTRL         = 8'h00;
  localparam logic [7:0]  A_STAT         = 8'h04;
  localparam logic [7:0]  A_FREQ0        = 8'h08;
  localparam logic [7:0]  A_FREQ1        = 8'h0c;
  localparam logic [2:0]  A_OUT0_BLK     = 3'h1;
  localparam logic [2:0]  A_OUT1_BLK     = 3'h2;
  // Word index inside an output block
  localparam logic [2:0]  F_CFG          = 3'h0;
  localparam logic [2:0]  F_FBASE        = 3'h1;
  localparam logic [2:0]  F_FSPAN        = 3'h2;
  localparam logic [2:0]  F_VMIN         = 3'h3;
  localparam logic [2:0]  F_VMAX         = 3'h4;
  localparam logic [2:0]  F_FVAL         = 3'h5;
  localparam logic [2:0]  F_UPP          = 3'h6;
  localparam logic [2:0]  F_PW           = 3'h7;
  ////////////////////////////////////////////////////////////////////////////
  // Configuration word fields, then control and status register bits
  localparam int          CFG_W          = 7;
  localparam int          CFG_EN         = 0;
  localparam int          CFG_MODE       = 1;
  localparam int          CFG_DRV        = 2;
  localparam int          CFG_POL        = 3;
  localparam int          CFG_ERR_LSB    = 4;
  localparam int          CFG_SRC        = 6;
  localparam int          CTRL_LINK      = 0;
  localparam int          ST_GATE        = 0;
  localparam int          ST_MERR        = 1;
  localparam int          ST_PIN_LSB     = 2;
  // Error response codes
  localparam logic [1:0]  ERR_LO         = 2'h0;
  localparam logic [1:0]  ERR_HI         = 2'h1;
  localparam logic [1:0]  ERR_HOLD       = 2'h2;
  localparam logic [1:0]  ERR_VAL        = 2'h3;
  // Reset values
  localparam logic [13:0] RST_FSPAN      = 14'h2710;
  localparam logic [15:0] RST_VMAX       = 16'hffff;
  localparam logic [15:0] RST_UPP        = 16'h0001;
  localparam logic [7:0]  RST_PW         = 8'h01;
  typedef enum logic [1:0] {TS_IDLE, TS_ACT, TS_GAP} ftp_tot_e;
endpackage

// ===== core/ftp_freq_gen.sv
`timescale 1ns/1ns
module ftp_freq_gen
  import ftp_pkg::*;
#(
  parameter int FW = 14,
  parameter int VW = 16
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ena,
  input  wire logic [FW-1:0] fbase,
  input  wire logic [FW-1:0] fspan,
  input  wire logic [FW-1:0] fval,
  input  wire logic [VW-1:0] vmin,
  input  wire logic [VW-1:0] vmax,
  input  wire logic [VW-1:0] pv,
  input  wire logic          meter_err,
  input  wire logic [1:0]    err_sel,
  output logic               wave_a,
  output logic               wave_b,
  output logic [FW-1:0]      freq_now
);
  localparam int NW = FW + VW;
  localparam logic [ACC_W-1:0] MOD   = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] HALF  = ACC_W'(CLK_HZ / 2);
  // Offset that makes the second wave lag by a quarter period
  localparam logic [ACC_W-1:0] LAG   = ACC_W'(CLK_HZ - CLK_HZ / 4);
  if (F_MAX_HZ >= 2**FW || CLK_HZ >= 2**ACC_W || 4 * F_MAX_HZ > CLK_HZ)
    $error("ftp_freq_gen: widths cannot hold the frequency range");

  function automatic logic [FW-1:0] lim(input logic [FW:0] f);
    return (f > (FW+1)'(F_MAX_HZ)) ? FW'(F_MAX_HZ) : f[FW-1:0];
  endfunction

  logic [FW-1:0]          df_w;
  logic [VW-1:0]          den_w;
  logic [VW-1:0]          dv_w;
  logic [NW-1:0]          num_w;
  logic [NW-1:0]          q_reg;
  logic [VW:0]            r_reg;
  logic [VW:0]            r_sh;
  logic [VW-1:0]          den_reg;
  logic [FW-1:0]          base_reg;
  logic [$clog2(NW+1)-1:0] cnt_reg;
  logic [FW-1:0]          lin_reg;
  logic [FW-1:0]          good_reg;
  logic [FW-1:0]          tgt_w;
  logic [ACC_W-1:0]       acc_reg;
  logic [ACC_W:0]         sum_w;
  logic [ACC_W:0]         sq_w;

  // Linear map of parameter onto base..span
  assign df_w  = (fspan > fbase) ? fspan - fbase : '0;
  assign den_w = (vmax > vmin) ? vmax - vmin : '0;
  assign dv_w  = (pv <= vmin) ? '0 : (pv >= vmax) ? den_w : pv - vmin;
  assign num_w = {{VW{1'b0}}, df_w} * {{FW{1'b0}}, dv_w};
  assign r_sh  = {r_reg[VW-1:0], q_reg[NW-1]};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      q_reg    <= '0;
      r_reg    <= '0;
      den_reg  <= '0;
      base_reg <= '0;
      cnt_reg  <= '0;
      lin_reg  <= '0;
    end
    else if (cnt_reg == '0)
    begin
      lin_reg  <= (den_reg == '0) ? lim({1'b0, base_reg})
                                  : lim({1'b0, base_reg} + {1'b0, q_reg[FW-1:0]});
      q_reg    <= num_w;
      r_reg    <= '0;
      den_reg  <= den_w;
      base_reg <= fbase;
      cnt_reg  <= ($clog2(NW+1))'(NW);
    end
    else
    begin
      if (r_sh >= {1'b0, den_reg})
      begin
        r_reg <= r_sh - {1'b0, den_reg};
        q_reg <= {q_reg[NW-2:0], 1'b1};
      end
      else
      begin
        r_reg <= r_sh;
        q_reg <= {q_reg[NW-2:0], 1'b0};
      end
      cnt_reg <= cnt_reg - 1'b1;
    end

  // Error response
  always_comb
  begin
    tgt_w = lin_reg;
    if (meter_err)
      case (err_sel)
        ERR_LO:   tgt_w = lim({1'b0, fbase});
        ERR_HI:   tgt_w = lim({1'b0, fspan});
        ERR_HOLD: tgt_w = good_reg;
        default:  tgt_w = lim({1'b0, fval});
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      good_reg <= '0;
    else if (!meter_err)
      good_reg <= lin_reg;

  // Phase accumulator wraps at the clock rate
  assign sum_w = {1'b0, acc_reg} + {{(ACC_W+1-FW){1'b0}}, freq_now};
  assign sq_w  = {1'b0, acc_reg} + {1'b0, LAG};

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      acc_reg  <= '0;
      freq_now <= '0;
      wave_a   <= 1'b0;
      wave_b   <= 1'b0;
    end
    else
    begin
      freq_now <= ena ? tgt_w : '0;
      acc_reg  <= !ena ? '0 : (sum_w >= {1'b0, MOD}) ? ACC_W'(sum_w - {1'b0, MOD}) : sum_w[ACC_W-1:0];
      wave_a   <= ena && (acc_reg >= HALF);
      wave_b   <= ena && (((sq_w >= {1'b0, MOD}) ? ACC_W'(sq_w - {1'b0, MOD}) : sq_w[ACC_W-1:0]) >= HALF);
    end
endmodule

// ===== core/ftp_tot_gen.sv
`timescale 1ns/1ns
module ftp_tot_gen
  import ftp_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS,
  parameter int OW     = 4
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ena,
  input  wire logic        unit_tick,
  input  wire logic        gate_open,
  input  wire logic [15:0] upp,
  input  wire logic [7:0]  pw_ms,
  output logic             pulse
);
  if (MS_CYC < 1 || OW < 1)
    $error("ftp_tot_gen: bad parameters");

  ftp_tot_e                    st_reg;
  logic [15:0]                 unit_reg;
  logic [OW-1:0]               owe_reg;
  logic [$clog2(MS_CYC+1)-1:0] cyc_reg;
  logic [7:0]                  ms_reg;
  logic [7:0]                  len_w;
  logic                        run_w;
  logic                        inc_w;
  logic                        dec_w;
  logic                        ms_w;

  assign run_w = ena && gate_open;
  assign inc_w = run_w && unit_tick && (unit_reg + 16'h0001 >= upp);
  assign dec_w = run_w && st_reg == TS_IDLE && owe_reg != '0;
  assign len_w = (pw_ms < 8'(TOT_MIN_PW_MS)) ? 8'(TOT_MIN_PW_MS) : pw_ms;
  assign ms_w  = cyc_reg == ($clog2(MS_CYC+1))'(MS_CYC - 1);

  // Unit accumulation and owed pulses
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      unit_reg <= '0;
      owe_reg  <= '0;
    end
    else if (!run_w)
    begin
      unit_reg <= '0;
      owe_reg  <= '0;
    end
    else
    begin
      if (unit_tick)
        unit_reg <= inc_w ? '0 : unit_reg + 16'h0001;
      if (inc_w && !dec_w && owe_reg != '1)
        owe_reg <= owe_reg + 1'b1;
      else if (dec_w && !inc_w)
        owe_reg <= owe_reg - 1'b1;
    end

  // Pulse then equal gap, both at least one ms
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_reg  <= TS_IDLE;
      cyc_reg <= '0;
      ms_reg  <= '0;
      pulse   <= 1'b0;
    end
    else if (!run_w)
    begin
      st_reg  <= TS_IDLE;
      cyc_reg <= '0;
      pulse   <= 1'b0;
    end
    else
      case (st_reg)
        TS_IDLE:
          if (dec_w)
          begin
            st_reg  <= TS_ACT;
            cyc_reg <= '0;
            ms_reg  <= len_w;
            pulse   <= 1'b1;
          end
        default:
        begin
          cyc_reg <= ms_w ? '0 : cyc_reg + 1'b1;
          if (ms_w)
          begin
            ms_reg <= ms_reg - 8'h01;
            if (ms_reg == 8'h01)
            begin
              st_reg <= (st_reg == TS_ACT) ? TS_GAP : TS_IDLE;
              ms_reg <= len_w;
              pulse  <= 1'b0;
            end
          end
        end
      endcase
endmodule

// ===== sim/ftp_chk.sv
`timescale 1ns/1ns
module ftp_chk
  import ftp_pkg::*;
#(
  parameter int MS_CYC = CYC_PER_MS,
  parameter int S_MS   = MS_PER_S
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pv0,
  input wire logic [15:0] pv1,
  input wire logic [1:0]  vol_tick,
  input wire logic        meter_err,
  input wire logic        gate_in,
  input wire logic [1:0]  fto_pin,
  input wire logic [1:0]  fto_oe
);
  logic [1:0] lvl;
  // Pin level with the pull-up
  assign lvl = ~fto_oe | fto_pin;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_has_setup: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
  a_err_misalign: assert property (s_setup and paddr[1:0] != 2'b00 |=> pslverr && pready)
    else $error("misaligned access accepted");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  a_rdata_stable: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  a_idle_after_reset: assert property ($rose(presetn) |-> fto_oe == 2'b00 ##1 lvl == 2'b00)
    else $error("pin not idle after reset");
  a_pulse_min_width: assert property ($rose(lvl[0]) |=> lvl[0] [*8])
    else $error("pin high too short");
endmodule

// ===== sim/ftp_daq_model.sv
`timescale 1ns/1ns
module ftp_daq_model (
  input  wire logic       pclk,
  input  wire logic       clr,
  input  wire logic [1:0] fto_pin,
  input  wire logic [1:0] fto_oe,
  output logic [1:0]      lvl,
  output int              cnt0,
  output int              cnt1
);
  logic [1:0] lvl_q;
  // Pull-up holds a released pin high
  assign lvl = ~fto_oe | fto_pin;
  always_ff @(posedge pclk)
  begin
    lvl_q <= lvl;
    cnt0 <= clr ? 0 : cnt0 + int'(lvl[0] && !lvl_q[0]);
    cnt1 <= clr ? 0 : cnt1 + int'(lvl[1] && !lvl_q[1]);
  end
endmodule

// ===== sim/test_freq_totalizer_pulse_output.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("wrong value %s exp %0d got %0d", n, e, a); end end
module test_freq_totalizer_pulse_output;
  import ftp_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pv0 = 16'h0;
  logic [15:0] pv1 = 16'h0;
  logic [1:0]  vol_tick = 2'b00;
  logic        meter_err = 1'b0;
  logic        gate_in = 1'b1;
  logic [1:0]  fto_pin;
  logic [1:0]  fto_oe;
  logic        clr = 1'b1;
  logic [1:0]  lvl;
  logic [31:0] rd;
  logic        er;
  int          cnt0;
  int          cnt1;
  int          n;
  int          mismatches = 0;
  int          checks = 0;
  always #50 pclk = ~pclk;
  ftp_top #(.MS_CYC(10), .S_MS(5)) u_ftp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pv0(pv0), .pv1(pv1), .vol_tick(vol_tick), .meter_err(meter_err), .gate_in(gate_in), .fto_pin(fto_pin),
    .fto_oe(fto_oe));
  ftp_daq_model u_daq (.pclk(pclk), .clr(clr), .fto_pin(fto_pin), .fto_oe(fto_oe), .lvl(lvl), .cnt0(cnt0),
    .cnt1(cnt1));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    `CHK(s, e, rd)
  endtask
  function automatic logic [7:0] ob(input logic o, input logic [2:0] f);
    return {o ? A_OUT1_BLK : A_OUT0_BLK, f, 2'b00};
  endfunction
  // Waits for pin i to reach level v from the other level
  task automatic wedge(input int i, input logic v);
    n = 0;
    while (lvl[i] === v && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (lvl[i] !== v && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic tick(input int c);
    repeat (c)
    begin
      vol_tick <= 2'b01;
      @(posedge pclk);
      vol_tick <= 2'b00;
      cyc(60);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0]  ad [6];
    logic [31:0] ev [6];
    ad = '{8'h00, ob(1'b0, F_CFG), ob(1'b0, F_FSPAN), ob(1'b1, F_VMAX), ob(1'b0, F_UPP), ob(1'b1, F_PW)};
    ev = '{32'h0, 32'h0, 32'h2710, 32'hffff, 32'h1, 32'h1};
    foreach (ad[i]) rchk(ad[i], ev[i], "reset value");
    `CHK("pin oe", 2'b11, fto_oe)
    `CHK("pin level", 2'b00, lvl)
    apb(1'b0, 8'h02, 32'h0);
    `CHK("misaligned err", 1'b1, er)
    apb(1'b1, 8'hf0, 32'h1);
    `CHK("unmapped err", 1'b1, er)
    $display("test reset done");
  endtask
  task automatic t_tot();
    wr_cfg: begin
      apb(1'b1, ob(1'b0, F_UPP), 32'd2);
      apb(1'b1, ob(1'b0, F_PW), 32'd2);
      apb(1'b1, ob(1'b0, F_CFG), 32'h0f);
    end
    cyc(10);
    `CHK("oe0 push-pull", 1'b1, fto_oe[0])
    clr <= 1'b0;
    tick(1);
    `CHK("one unit", 0, cnt0)
    vol_tick <= 2'b01;
    @(posedge pclk);
    vol_tick <= 2'b00;
    wedge(0, 1'b1);
    wedge(0, 1'b0);
    `CHK("pulse width", 20, n)
    tick(2);
    `CHK("two pulses", 2, cnt0)
    gate_in <= 1'b0;
    cyc(2);
    apb(1'b0, A_STAT, 32'h0);
    `CHK("gate status", 1'b0, rd[ST_GATE])
    tick(4);
    `CHK("gated count", 2, cnt0)
    gate_in <= 1'b1;
    cyc(2);
    tick(2);
    `CHK("ungated count", 3, cnt0)
    $display("test totalizer done");
  endtask
  task automatic t_mix();
    logic [31:0] ev [4];
    ev = '{32'd1000, 32'd10000, 32'd4250, 32'd7777};
    apb(1'b1, ob(1'b1, F_FBASE), 32'd1000);
    apb(1'b1, ob(1'b1, F_FSPAN), 32'd14000);
    apb(1'b1, ob(1'b1, F_VMAX), 32'd100);
    apb(1'b1, ob(1'b1, F_FVAL), 32'd7777);
    pv1 <= 16'd25;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, ob(1'b1, F_CFG), 32'h05 | (c << 4));
      cyc(80);
      rchk(A_FREQ1, 32'd4250, "scaled freq");
      meter_err <= 1'b1;
      cyc(80);
      rchk(A_FREQ1, ev[c], "error freq");
      meter_err <= 1'b0;
    end
    rchk(ob(1'b0, F_FSPAN), 32'h2710, "own span");
    pv1 <= 16'd200;
    cyc(80);
    rchk(A_FREQ1, 32'd10000, "clamped freq");
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    tick(100);
    `CHK("tot beside freq", 50, cnt0)
    `CHK("freq edges", 1'b1, (cnt1 >= 5 && cnt1 <= 7))
    $display("test mixed done");
  endtask
  task automatic t_link();
    wedge(1, 1'b0);
    apb(1'b1, ob(1'b0, F_CFG), 32'h05);
    apb(1'b1, ob(1'b1, F_CFG), 32'h0);
    pv0 <= 16'hffff;
    apb(1'b1, 8'h00, 32'h1);
    cyc(100);
    rchk(A_FREQ1, 32'd10000, "linked freq");
    wedge(0, 1'b1);
    wedge(1, 1'b1);
    `CHK("quarter lag", 1'b1, (n >= 248 && n <= 252))
    $display("test linked done");
  endtask
  task automatic t_off();
    wedge(1, 1'b0);
    apb(1'b1, ob(1'b0, F_CFG), 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    cyc(5);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    tick(20);
    `CHK("off pulses", 0, cnt0 + cnt1)
    apb(1'b1, ob(1'b1, F_UPP), 32'd1);
    apb(1'b1, ob(1'b1, F_PW), 32'd1);
    clr <= 1'b1;
    apb(1'b1, ob(1'b1, F_CFG), 32'h43);
    cyc(2);
    clr <= 1'b0;
    cyc(520);
    `CHK("time pulses", 1'b1, (cnt1 >= 9 && cnt1 <= 11))
    $display("test off and time done");
  endtask
  initial
  begin
    cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_tot();
    t_mix();
    t_link();
    t_off();
    end_sim();
  end
  initial
  begin
    cyc(100000);
    mismatches++;
    end_sim();
  end
endmodule
bind ftp_top ftp_chk #(.MS_CYC(MS_CYC), .S_MS(S_MS)) u_ftp_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pv0(pv0), .pv1(pv1), .vol_tick(vol_tick), .meter_err(meter_err), .gate_in(gate_in),
  .fto_pin(fto_pin), .fto_oe(fto_oe));
